// ===== design/msr_bank.sv
// status and configuration register bank of the fieldbus module
//
// Function
// - eight mapping registers name the registers sent by master each cycle
// - mapping changes act only after save to flash and then reboot
// - seven read-only registers report hardware, software, comms info
// - count SPI CRC errors since power up, report in own register
// - input register bits 0..3 hold digital inputs, upper bits reserved
// - basic variant gives only first input; extended variant gives four
// - status bit 7 set while no communication with motor
// - status bit 9 set while cyclic PLC exchange runs, not under Modbus
// - status bit 10 set when distributed clocks on, one protocol only
// - status bit 12 tool over serial, bit 11 tool over UDP
// - status bit 13 set on motor PLL synchronisation error
// - status bit 14 negative limit, bit 15 positive limit active
// - status bit 16 marks SPI used for internal cyclic traffic
// - status bit 17 warns motor firmware too old
// - status bit 18 warns cyclic data exchange is blocked
// - protocol register reports one of six codes 0x34 to 0x39
// - IP after a reboot is 192.168.0.N, N the last MAC byte in decimal; after reset it is 192.168.0.0
`include "msr_consts.svh"

module msr_bank #(
    parameter logic [7:0]   PROTOCOL_CODE    = 8'h34,
    parameter bit           EXTENDED_VARIANT = 1'b1,
    parameter logic [223:0] MODULE_INFO      = {7{32'h00000000}}
) (
    // clock, reset, enable
    input  wire logic                       sys_clk_in,
    input  wire logic                       rst_in,
    input  wire logic                       ce_in,
    // register access
    input  wire msr_pkg::msr_reg_req_t      reg_req_in,
    output logic                [31:0]      rd_data_out,
    output logic                            rd_valid_out,
    output logic                            rd_unmapped_out,
    // flash and reboot commands
    input  wire logic                       save_flash_in,
    input  wire logic                       reboot_in,
    // cyclic mapping lookup
    input  wire logic           [2:0]       map_sel_in,
    output logic                [31:0]      cyclic_map_out,
    // conditions from the module and motor
    input  wire msr_pkg::msr_status_flags_t status_in,
    input  wire logic                       crc_error_in,
    // pins
    input  wire logic           [3:0]       module_inputs_in,
    input  wire logic           [7:0]       mac_id_low_in,
    // derived values
    output logic                [31:0]      ip_address_out,
    output logic                            booting_out
);

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    function automatic logic in_window(input logic [7:0] addr,
                                       input logic [7:0] base,
                                       input logic [7:0] count);
        in_window = (addr >= base) && (addr < 8'(base + count));
    endfunction : in_window

    function automatic logic [2:0] slot_of(input logic [7:0] addr,
                                           input logic [7:0] base);
        logic [7:0] diff;
        diff    = 8'(addr - base);
        slot_of = diff[2:0];
    endfunction : slot_of

    function automatic logic proto_legal(input logic [7:0] code);
        proto_legal = (code >= `MSR_PROTO_FIRST) &&
                      (code <= `MSR_PROTO_LAST);
    endfunction : proto_legal

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    msr_pkg::msr_state_t state;
    logic [31:0]         map_pending [8];
    logic [31:0]         map_saved   [8];
    logic [31:0]         map_active  [8];
    logic [31:0]         crc_count;
    logic [31:0]         din_word;
    logic [31:0]         status_word;
    logic [3:0]          din_sync;
    logic [7:0]          mac_sync;
    logic [7:0]          proto_code;
    logic                wr_map;
    logic [2:0]          wr_slot;

    assign wr_map  = reg_req_in.wr &&
                     in_window(reg_req_in.addr, `MSR_MAP_BASE,
                               `MSR_MAP_COUNT);
    assign wr_slot = slot_of(reg_req_in.addr, `MSR_MAP_BASE);

    // unsupported codes fall back to the first legal one
    assign proto_code = proto_legal(PROTOCOL_CODE) ? PROTOCOL_CODE
                                                   : `MSR_PROTO_FIRST;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    msr_sync #(.WIDTH(4)) u_din_sync (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .ce_in      (ce_in),
        .async_in   (module_inputs_in),
        .sync_out   (din_sync)
    );

    msr_sync #(.WIDTH(8)) u_mac_sync (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .ce_in      (ce_in),
        .async_in   (mac_id_low_in),
        .sync_out   (mac_sync)
    );

    // ---------------------------------------------------------------
    // boot sequencing
    // ---------------------------------------------------------------
    // one boot cycle after reset or reboot, then steady running
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= msr_pkg::MSR_BOOT;
        end else if (ce_in) begin
            unique case (state)
                msr_pkg::MSR_BOOT: state <= msr_pkg::MSR_RUN;
                msr_pkg::MSR_RUN: begin
                    if (reboot_in) begin
                        state <= msr_pkg::MSR_BOOT;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            booting_out <= 1'b1;
        end else if (ce_in) begin
            booting_out <= (state == msr_pkg::MSR_RUN) ? reboot_in : 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // cyclic mapping: pending, saved, active
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 8; i++) begin
                map_pending[i] <= `MSR_MAP_RESET;
            end
        end else if (ce_in && wr_map) begin
            map_pending[wr_slot] <= reg_req_in.data;
        end
    end

    // a write in the same cycle as a save is not yet part of the copy
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 8; i++) begin
                map_saved[i] <= `MSR_MAP_RESET;
            end
        end else if (ce_in && save_flash_in) begin
            for (int i = 0; i < 8; i++) begin
                map_saved[i] <= map_pending[i];
            end
        end
    end

    // the exchange only ever sees what the last boot loaded
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 8; i++) begin
                map_active[i] <= `MSR_MAP_RESET;
            end
        end else if (ce_in && state == msr_pkg::MSR_BOOT) begin
            for (int i = 0; i < 8; i++) begin
                map_active[i] <= map_saved[i];
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cyclic_map_out <= `MSR_MAP_RESET;
        end else if (ce_in) begin
            cyclic_map_out <= map_active[map_sel_in];
        end
    end

    // ---------------------------------------------------------------
    // SPI CRC error counter
    // ---------------------------------------------------------------
    // saturates rather than wrapping, so a huge count never reads small
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            crc_count <= `MSR_WORD_ZERO;
        end else if (ce_in && crc_error_in &&
                     crc_count != `MSR_CRC_MAX) begin
            crc_count <= crc_count + `MSR_CRC_ONE;
        end
    end

    // ---------------------------------------------------------------
    // digital inputs and status word
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            din_word <= `MSR_WORD_ZERO;
        end else if (ce_in) begin
            din_word <= {28'h0000000, din_sync &
                         (EXTENDED_VARIANT ? `MSR_DIN_ALL_MASK
                                           : `MSR_DIN_FIRST_MASK)};
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_word <= `MSR_WORD_ZERO;
        end else if (ce_in) begin
            status_word <= `MSR_WORD_ZERO;
            status_word[`MSR_ST_NO_MOTOR]   <= status_in.motor_comm_lost;
            status_word[`MSR_ST_CYCLIC]     <= status_in.cyclic_running &&
                (proto_code != `MSR_PROTO_NO_CYC);
            status_word[`MSR_ST_DCLK]       <= status_in.distributed_clock_on
                && (proto_code == `MSR_PROTO_DCLK);
            status_word[`MSR_ST_UDP]        <= status_in.tool_udp;
            status_word[`MSR_ST_RS232]      <= status_in.tool_rs232;
            status_word[`MSR_ST_SYNC]       <= status_in.motor_sync_error;
            status_word[`MSR_ST_NEG_LIMIT]  <=
                status_in.negative_limit_flag;
            status_word[`MSR_ST_POS_LIMIT]  <=
                status_in.positive_limit_flag;
            status_word[`MSR_ST_SPI_CYCLIC] <= status_in.spi_cyclic_used;
            status_word[`MSR_ST_FW_OLD]     <= status_in.motor_fw_old;
            status_word[`MSR_ST_BLOCKED]    <= status_in.cyclic_blocked;
        end
    end

    // ---------------------------------------------------------------
    // default IP address
    // ---------------------------------------------------------------
    // the host octet is the binary byte value, which reads as decimal
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ip_address_out <= {`MSR_IP_PREFIX, `MSR_IP_HOST_RESET};
        end else if (ce_in && state == msr_pkg::MSR_BOOT) begin
            ip_address_out <= {`MSR_IP_PREFIX, mac_sync};
        end
    end

    // ---------------------------------------------------------------
    // register reads
    // ---------------------------------------------------------------
    // writes to read-only or unknown numbers simply fall away
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out     <= `MSR_WORD_ZERO;
            rd_valid_out    <= 1'b0;
            rd_unmapped_out <= 1'b0;
        end else if (ce_in) begin
            rd_valid_out    <= reg_req_in.rd;
            rd_unmapped_out <= 1'b0;
            if (reg_req_in.rd) begin
                rd_data_out <= `MSR_WORD_ZERO;
                if (in_window(reg_req_in.addr, `MSR_MAP_BASE,
                              `MSR_MAP_COUNT)) begin
                    rd_data_out <= map_pending[
                        slot_of(reg_req_in.addr, `MSR_MAP_BASE)];
                end else if (in_window(reg_req_in.addr, `MSR_INFO_BASE,
                                       `MSR_INFO_COUNT)) begin
                    rd_data_out <= MODULE_INFO[32 * slot_of(
                        reg_req_in.addr, `MSR_INFO_BASE) +: 32];
                end else if (reg_req_in.addr == `MSR_CRC_REG) begin
                    rd_data_out <= crc_count;
                end else if (reg_req_in.addr == `MSR_DIN_REG) begin
                    rd_data_out <= din_word;
                end else if (reg_req_in.addr == `MSR_STATUS_REG) begin
                    rd_data_out <= status_word;
                end else if (reg_req_in.addr == `MSR_PROTO_REG) begin
                    rd_data_out <= {24'h000000, proto_code};
                end else begin
                    rd_unmapped_out <= 1'b1;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    chk_map_pending_write: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        ce_in && wr_map |=> map_pending[$past(wr_slot)] ==
                            $past(reg_req_in.data))
        else $error("mapping write not stored");

    chk_map_active_hold: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        ce_in && state == msr_pkg::MSR_RUN && wr_map |=>
            map_active[$past(wr_slot)] == $past(map_active[wr_slot]))
        else $error("mapping changed without reboot");

    chk_map_reboot_load: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && state == msr_pkg::MSR_RUN && reboot_in) ##1 ce_in
            |=> map_active[0] == $past(map_saved[0]))
        else $error("reboot did not load saved mapping");

    chk_crc_increment: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        ce_in && crc_error_in && crc_count != `MSR_CRC_MAX |=>
            crc_count == $past(crc_count) + `MSR_CRC_ONE)
        else $error("crc error not counted");

    chk_din_upper_zero: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        ce_in && reg_req_in.rd && reg_req_in.addr == `MSR_DIN_REG |=>
            rd_data_out[31:4] == 28'h0000000 &&
            (EXTENDED_VARIANT || rd_data_out[3:1] == 3'h0))
        else $error("input register shows absent inputs");

    chk_status_motor: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        ce_in |=> status_word[`MSR_ST_NO_MOTOR] ==
                  $past(status_in.motor_comm_lost))
        else $error("no-motor bit does not follow condition");

    chk_status_cyclic: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        ce_in |=> status_word[`MSR_ST_CYCLIC] ==
            ($past(status_in.cyclic_running) &&
             proto_code != `MSR_PROTO_NO_CYC))
        else $error("cyclic running bit wrong");

    chk_status_reserved: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        ce_in ##1 1'b1 |-> (status_word & ~`MSR_ST_USED_MASK) ==
                          `MSR_WORD_ZERO)
        else $error("reserved status bit set");

    chk_proto_read: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        ce_in && reg_req_in.rd && reg_req_in.addr == `MSR_PROTO_REG |=>
            rd_data_out[7:0] >= `MSR_PROTO_FIRST &&
            rd_data_out[7:0] <= `MSR_PROTO_LAST)
        else $error("protocol code out of range");

    chk_ip_host: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        ce_in && state == msr_pkg::MSR_BOOT |=>
            ip_address_out == {`MSR_IP_PREFIX, $past(mac_sync)})
        else $error("default address not derived from MAC byte");

endmodule : msr_bank

// ===== include/msr_consts.svh
// register numbers, field positions and fixed values of the status bank
`ifndef MSR_CONSTS_SVH
`define MSR_CONSTS_SVH

// ---------------------------------------------------------------
// register numbers
// ---------------------------------------------------------------
`define MSR_MAP_BASE       8'h18
`define MSR_MAP_COUNT      8'h08
`define MSR_INFO_BASE      8'h20
`define MSR_INFO_COUNT     8'h07
`define MSR_CRC_REG        8'h27
`define MSR_DIN_REG        8'h2f
`define MSR_STATUS_REG     8'h30
`define MSR_PROTO_REG      8'h31

// ---------------------------------------------------------------
// status word bit positions
// ---------------------------------------------------------------
`define MSR_ST_NO_MOTOR    7
`define MSR_ST_CYCLIC      9
`define MSR_ST_DCLK        10
`define MSR_ST_UDP         11
`define MSR_ST_RS232       12
`define MSR_ST_SYNC        13
`define MSR_ST_NEG_LIMIT   14
`define MSR_ST_POS_LIMIT   15
`define MSR_ST_SPI_CYCLIC  16
`define MSR_ST_FW_OLD      17
`define MSR_ST_BLOCKED     18
`define MSR_ST_USED_MASK   32'h0007fe80

// ---------------------------------------------------------------
// protocol codes, input field, address defaults
// ---------------------------------------------------------------
`define MSR_PROTO_FIRST    8'h34
`define MSR_PROTO_DCLK     8'h35
`define MSR_PROTO_NO_CYC   8'h38
`define MSR_PROTO_LAST     8'h39
`define MSR_DIN_FIRST_MASK 4'h1
`define MSR_DIN_ALL_MASK   4'hf
`define MSR_IP_PREFIX      24'hc0a800
`define MSR_IP_HOST_RESET  8'h00
`define MSR_MAP_RESET      32'h00000000
`define MSR_WORD_ZERO      32'h00000000
`define MSR_CRC_MAX        32'hffffffff
`define MSR_CRC_ONE        32'h00000001

`endif

// ===== include/msr_pkg.sv
// types shared by the module status register bank
package msr_pkg;

    // ---------------------------------------------------------------
    // register access request from the exchange logic
    // ---------------------------------------------------------------
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] data;
    } msr_reg_req_t;

    // ---------------------------------------------------------------
    // module and motor conditions folded into the status word
    // ---------------------------------------------------------------
    typedef struct packed {
        logic motor_comm_lost;
        logic cyclic_running;
        logic distributed_clock_on;
        logic tool_udp;
        logic tool_rs232;
        logic motor_sync_error;
        logic negative_limit_flag;
        logic positive_limit_flag;
        logic spi_cyclic_used;
        logic motor_fw_old;
        logic cyclic_blocked;
    } msr_status_flags_t;

    typedef enum logic [0:0] {
        MSR_BOOT,
        MSR_RUN
    } msr_state_t;

endpackage : msr_pkg

// ===== design/msr_sync.sv
// two-stage synchroniser for pin inputs
module msr_sync #(
    parameter int WIDTH = 4
) (
    // clock, reset, enable
    input  wire logic             sys_clk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    // pins and synchronised copy
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    // first stage feeds only the second stage
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage_one <= '0;
            sync_out  <= '0;
        end else if (ce_in) begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule : msr_sync

// ===== verif/msr_master_model.sv
// fieldbus master model driving register, save and reboot requests
module msr_master_model (
    // clock
    input  wire logic             sys_clk_in,
    // requests towards the bank
    output msr_pkg::msr_reg_req_t req_out,
    output logic                  save_out,
    output logic                  reboot_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        req_out = '0;
        save_out = 1'b0;
        reboot_out = 1'b0;
    end

    task automatic access(input logic rd, input logic wr,
                          input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        req_out <= '{rd: rd, wr: wr, addr: a, data: d};
        @(posedge sys_clk_in);
        // released lines show inverted junk, never the old value
        req_out <= '{rd: 1'b0, wr: 1'b0, addr: ~a, data: ~d};
    endtask : access

    // save and reboot are separate one-cycle commands
    task automatic command(input logic reboot);
        @(posedge sys_clk_in);
        save_out <= ~reboot;
        reboot_out <= reboot;
        @(posedge sys_clk_in);
        save_out <= 1'b0;
        reboot_out <= 1'b0;
    endtask : command
endmodule : msr_master_model

// ===== verif/test_module_status_registers.sv
// self-checking bench of the module status register bank
module test_module_status_registers;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end

    localparam logic [223:0] INFO = {32'ha6, 32'ha5, 32'ha4, 32'ha3,
                                     32'ha2, 32'ha1, 32'ha0};
    logic                       sys_clk_in = 1'b0;
    logic                       rst_in     = 1'b1;
    logic                       ce         = 1'b1;
    msr_pkg::msr_reg_req_t      req;
    logic                       save;
    logic                       reboot;
    logic [2:0]                 map_sel    = 3'h0;
    msr_pkg::msr_status_flags_t st         = '0;
    logic                       crc_err    = 1'b0;
    logic [3:0]                 pins       = 4'h0;
    logic [7:0]                 mac        = 8'h00;
    logic [31:0]                rd_data;
    logic [31:0]                rd_data_b;
    logic [31:0]                cyc_map;
    logic [31:0]                ip;
    logic                       rd_valid;
    logic                       rd_unm;
    logic                       booting;
    logic [64:0]                exp_q[$];
    logic [64:0]                mon_exp;
    logic [31:0]                st_word;
    logic [31:0]                map_w[8];
    int                         errors     = 0;
    int                         checks     = 0;
    int                         n;

    always #20 sys_clk_in = ~sys_clk_in;

    msr_master_model master (.sys_clk_in(sys_clk_in), .req_out(req),
        .save_out(save), .reboot_out(reboot));

    msr_bank #(.PROTOCOL_CODE(8'h35), .EXTENDED_VARIANT(1'b1),
               .MODULE_INFO(INFO)) dut (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce),
        .reg_req_in(req), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
        .rd_unmapped_out(rd_unm), .save_flash_in(save),
        .reboot_in(reboot), .map_sel_in(map_sel),
        .cyclic_map_out(cyc_map), .status_in(st), .crc_error_in(crc_err),
        .module_inputs_in(pins), .mac_id_low_in(mac),
        .ip_address_out(ip), .booting_out(booting));

    // second bank: basic variant under the protocol without bit 9
    msr_bank #(.PROTOCOL_CODE(8'h38), .EXTENDED_VARIANT(1'b0),
               .MODULE_INFO(INFO)) dut_basic (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce),
        .reg_req_in(req), .rd_data_out(rd_data_b), .rd_valid_out(),
        .rd_unmapped_out(), .save_flash_in(save),
        .reboot_in(reboot), .map_sel_in(map_sel),
        .cyclic_map_out(), .status_in(st), .crc_error_in(crc_err),
        .module_inputs_in(pins), .mac_id_low_in(mac),
        .ip_address_out(), .booting_out());

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] st_exp(
            input msr_pkg::msr_status_flags_t f);
        logic [31:0] w;
        w = 32'h0;
        for (int k = 0; k < 10; k++) w[18 - k] = f[k];
        w[7] = f[10];
        return w;
    endfunction : st_exp

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] d,
                          input logic unm);
        logic [31:0] db;
        // basic bank: inputs two to four absent, bits 9 and 10 forced low
        db = (a == 8'h2f) ? (d & 32'h1) : (a == 8'h30) ?
             (d & ~32'h600) : (a == 8'h31) ? 32'h38 : d;
        exp_q.push_back({unm, d, db});
        master.access(1'b1, 1'b0, a, 32'h0);
    endtask : rd_chk

    task automatic finish_test();
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    // an answer with no note pending compares against unknown and fails
    always @(posedge sys_clk_in) begin
        if (rd_valid === 1'b1) begin
            mon_exp = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
            `CHK({rd_unm, rd_data, rd_data_b}, mon_exp)
        end
    end

    initial begin
        repeat (2000) @(posedge sys_clk_in);
        errors++;
        finish_test();
    end

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'hf8599f59));
        mac = 8'($urandom());
        repeat (16) @(posedge sys_clk_in);
        `CHK(ip, 32'hc0a80000)
        rst_in <= 1'b0;
        for (int k = 0; k < 7; k++) begin
            rd_chk(8'h20 + 8'(k), 32'ha0 + 32'(k), 1'b0);
        end
        rd_chk(8'h31, 32'h35, 1'b0);
        rd_chk(8'h28, 32'h0, 1'b1);
        master.access(1'b0, 1'b1, 8'h31, 32'hffffffff);
        rd_chk(8'h31, 32'h35, 1'b0);
        for (int k = 0; k < 8; k++) begin
            map_w[k] = $urandom();
            master.access(1'b0, 1'b1, 8'h18 + 8'(k), map_w[k]);
        end
        for (int k = 0; k < 8; k++) begin
            rd_chk(8'h18 + 8'(k), map_w[k], 1'b0);
        end
        // reboot without save keeps the old mapping
        map_sel <= 3'h7;
        master.command(1'b1);
        repeat (4) @(posedge sys_clk_in);
        `CHK(cyc_map, 32'h0)
        master.command(1'b0);
        repeat (2) @(posedge sys_clk_in);
        `CHK(cyc_map, 32'h0)
        master.command(1'b1);
        #1;
        `CHK(booting, 1'b1)
        repeat (4) @(posedge sys_clk_in);
        `CHK(ip, {24'hc0a800, mac})
        for (int k = 0; k < 8; k++) begin
            map_sel <= 3'(k);
            repeat (2) @(posedge sys_clk_in);
            `CHK(cyc_map, map_w[k])
        end
        // one-hot walk over every flag, then random mixes
        for (int k = 0; k < 15; k++) begin
            st <= msr_pkg::msr_status_flags_t'(
                      (k < 11) ? 11'(1 << k) : 11'($urandom()));
            repeat (2) @(posedge sys_clk_in);
            st_word = st_exp(st);
            rd_chk(8'h30, st_word, 1'b0);
        end
        n = 1 + int'($urandom() % 20);
        repeat (n) begin
            crc_err <= 1'b1;
            @(posedge sys_clk_in);
        end
        // frozen cycles must not count the still-raised error
        ce <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        ce <= 1'b1;
        crc_err <= 1'b0;
        rd_chk(8'h27, 32'(n), 1'b0);
        pins <= 4'($urandom());
        repeat (4) @(posedge sys_clk_in);
        rd_chk(8'h2f, {28'h0, pins}, 1'b0);
        repeat (4) @(posedge sys_clk_in);
        `CHK(exp_q.size(), 0)
        finish_test();
    end
endmodule : test_module_status_registers
